//--- adcwr_pkg.sv
// constants, register layout and state type of the converter window/reference control
package adcwr_pkg;

   // ----------------------------------------------------------------
   // special-function addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL0 = 8'hE8;  // converter_control_0, bit-addressable
   localparam logic [7:0] ADDR_GTL   = 8'hC3;  // greater_than_limit_low
   localparam logic [7:0] ADDR_GTH   = 8'hC4;  // greater_than_limit_high
   localparam logic [7:0] ADDR_LTL   = 8'hC5;  // less_than_limit_low
   localparam logic [7:0] ADDR_LTH   = 8'hC6;  // less_than_limit_high
   localparam logic [7:0] ADDR_REFC  = 8'hD1;  // reference_control

   // ----------------------------------------------------------------
   // converter_control_0 bit positions
   // ----------------------------------------------------------------
   localparam int BIT_ENABLE = 7;
   localparam int BIT_BURST  = 6;
   localparam int BIT_DONE   = 5;
   localparam int BIT_BUSY   = 4;
   localparam int BIT_WIN    = 3;
   localparam int TRIG_LSB   = 0;

   // ----------------------------------------------------------------
   // reference_control bit positions
   // ----------------------------------------------------------------
   localparam int REF_TEMP_SENSOR_ENABLE_BIT = 2;
   localparam int REF_SEL_LSB   = 3;
   localparam int REF_GND_BIT   = 5;
   localparam int REF_LVL_BIT   = 7;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL0_RESET = 8'h00;
   localparam logic [7:0] REFC_RESET  = 8'h00;
   localparam logic [7:0] LIMIT_RESET = 8'h00;
   localparam logic [7:0] RDATA_IDLE  = 8'h00;

   // ----------------------------------------------------------------
   // field encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
   localparam logic [2:0] TRIG_TIMER0   = 3'h1;
   localparam logic [2:0] TRIG_TIMER2   = 3'h2;
   localparam logic [2:0] TRIG_TIMER3   = 3'h3;
   localparam logic [2:0] TRIG_PIN      = 3'h4;

   localparam logic [1:0] REF_EXTERNAL = 2'h0;
   localparam logic [1:0] REF_SUPPLY   = 2'h1;
   localparam logic [1:0] REF_REG_1V8  = 2'h2;
   localparam logic [1:0] REF_INTERNAL = 2'h3;

   localparam logic LVL_1V65 = 1'b0;
   localparam logic LVL_2V4  = 1'b1;

   // ----------------------------------------------------------------
   // whole register state of the control block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctrl0;
      logic [7:0] gtl;
      logic [7:0] gth;
      logic [7:0] ltl;
      logic [7:0] lth;
      logic [7:0] refc;
      logic       pin_s1;
      logic       pin_s2;
      logic       pin_prev;
      logic       start;
      logic [7:0] rdata;
      logic [1:0] ref_sel;
      logic       ref_lvl;
      logic       ref_power;
      logic       gnd_track;
      logic       gnd_convert;
      logic       temp_en;
   } adcwr_state_t;

endpackage

//--- adcwr_window.sv
// window comparator: decides inside/outside from the limits and tests one result
`timescale 1ns/1ps
module adcwr_window
#(
   parameter int WIDTH = 16
)
(
   // limits and sample
   input  wire logic [WIDTH-1:0] greater_than_limit,
   input  wire logic [WIDTH-1:0] less_than_limit,
   input  wire logic [WIDTH-1:0] result_value,
   // decision
   output logic                  window_hit
);

   // the comparators need at least two bits to be meaningful
   if (WIDTH < 2)
   begin : g_bad_width
      $error("adcwr_window: WIDTH must be at least 2");
   end

   logic inside_mode;
   logic above_gt;
   logic below_lt;

   // [R6] unsigned mode pick
   assign inside_mode = less_than_limit > greater_than_limit;
   assign above_gt    = result_value > greater_than_limit;
   assign below_lt    = result_value < less_than_limit;

   // [R3] mode from limits only
   always_comb
   begin
      if (inside_mode)
         // [R4] strict inside window
         window_hit = above_gt && below_lt;
      else
         // [R5] strict outside window
         window_hit = below_lt || above_gt;
   end

endmodule

//--- adcwr_ctrl.sv
// converter window detector, reference/ground selection and control register 0
//
// Overview of operation
// [R1] Every new result is checked against the greater-than and less-than limits.
// [R2] Window hit flag is readable for polling and driven out as interrupt source.
// [R3] Inside or outside detection follows from the limit values alone, no mode bit.
// [R4] Inside mode flags results strictly between lower and upper limit.
// [R5] Outside mode flags results strictly below lower or above upper limit.
// [R6] Less-than above greater-than means inside; otherwise outside; unsigned 16-bit.
// [R7] Reference select 00 routes the external reference pin.
// [R8] Reference select 11 uses the internal high-speed reference.
// [R9] Code 01 selects the supply pin, code 10 the 1.8 V regulated supply.
// [R10] Internal reference powers up only while a conversion needs it.
// [R11] One level bit picks 1.65 V or 2.4 V internal reference.
// [R12] Ground select 1 takes converter ground from the analog ground pin.
// [R13] Selected analog ground applies in tracking and in conversion.
// [R14] Temperature sensor channel always samples against chip ground.
// [R15] 1.65 V internal reference forces chip ground during conversion.
// [R16] Sensor enable bit switches sensor; cleared leaves its output high-impedance.
// [R17] Control register 0 at 0xE8, bit-addressable, resets to zero, fixed layout.
// [R18] Hardware sets window flag, only software clears it; may request interrupt.
// [R19] Hardware sets done flag per conversion or burst; only software clears it.
// [R20] Trigger field picks busy write, three timer overflows or pin rising edge.
`timescale 1ns/1ps
module adcwr_ctrl
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // special-function register port
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   // single-bit writes into bit-addressable space
   input  wire logic [7:0]  sfr_bit_addr,
   input  wire logic        sfr_bit_wr,
   input  wire logic        sfr_bit_wdata,
   // converter core status
   input  wire logic        result_valid,
   input  wire logic [15:0] result_value,
   input  wire logic        conversion_complete,
   input  wire logic        converter_active,
   input  wire logic        temp_channel_selected,
   // start sources
   input  wire logic        timer0_overflow,
   input  wire logic        timer2_overflow,
   input  wire logic        timer3_overflow,
   input  wire logic        external_convert_start_pin,
   // converter control
   output logic             conv_start,
   output logic             converter_enable,
   output logic             burst_enable,
   output logic             window_hit_flag,
   output logic             conversion_done_flag,
   // reference and ground multiplexers
   output logic      [1:0]  reference_select,
   output logic             internal_reference_level,
   output logic             internal_ref_power,
   output logic             analog_ground_track,
   output logic             analog_ground_convert,
   output logic             temp_sensor_enable
);

   // ------------------------------
   // register map
   // ------------------------------
   // converter_control_0, byte and bit access:
   //    7    converter_enable
   //    6    burst_enable
   //    5    conversion_done_flag, set by hardware
   //    4    busy_start_bit, a one starts a software trigger
   //    3    window_hit_flag, set by hardware
   //    2:0  trigger_source_select, 101 to 111 start nothing
   // reference_control, byte access only:
   //    7    internal_reference_level, 0 low, 1 high
   //    5    ground_select
   //    4:3  reference_select
   //    2    temp_sensor_enable
   //    6, 1:0 stored and read back only
   // limits: high byte on 15:8, each byte live on its write
   // limitations:
   //    triggers while busy are dropped, not queued
   //    the pin edge starts about three clocks late
   //    timers are same-clock pulses, not synchronised
   //    a zero written to busy never aborts a conversion
   //    a write clearing both enables blocks a start
   //    unmapped writes are dropped, unmapped reads give zero
   //    equal limits select outside detection
   //    reference and ground outputs trail by one clock; convert ground and reference power trail a select change by two

   // ------------------------------
   // elaboration checks
   // ------------------------------
   // bit decode assumes an eight-aligned control address
   if (adcwr_pkg::ADDR_CTRL0[2:0] != 3'h0)
   begin : g_bad_ctrl_addr
      $error("adcwr_ctrl: control address not eight-aligned");
   end

   // a clash would shadow one register behind another
   if (adcwr_pkg::ADDR_GTL == adcwr_pkg::ADDR_GTH
       || adcwr_pkg::ADDR_LTL == adcwr_pkg::ADDR_LTH
       || adcwr_pkg::ADDR_GTL == adcwr_pkg::ADDR_LTL
       || adcwr_pkg::ADDR_GTH == adcwr_pkg::ADDR_LTH
       || adcwr_pkg::ADDR_REFC == adcwr_pkg::ADDR_CTRL0)
   begin : g_bad_map
      $error("adcwr_ctrl: register addresses collide");
   end

   // fields must stay inside their byte
   if (adcwr_pkg::TRIG_LSB > 5 || adcwr_pkg::REF_SEL_LSB > 6
       || adcwr_pkg::REF_GND_BIT > 7 || adcwr_pkg::REF_LVL_BIT > 7
       || adcwr_pkg::REF_TEMP_SENSOR_ENABLE_BIT > 7 || adcwr_pkg::BIT_ENABLE > 7)
   begin : g_bad_field
      $error("adcwr_ctrl: register field outside its byte");
   end

   // the window flag bit must clear the trigger field
   if (adcwr_pkg::BIT_WIN < adcwr_pkg::TRIG_LSB + 3)
   begin : g_bad_ctrl_field
      $error("adcwr_ctrl: window bit overlaps trigger field");
   end

   // ------------------------------
   // state and limit assembly
   // ------------------------------
   adcwr_pkg::adcwr_state_t s_q;
   adcwr_pkg::adcwr_state_t s_d;

   logic        win_hit;
   logic [15:0] gt_limit;
   logic [15:0] lt_limit;

   // limits assembled from their byte registers
   assign gt_limit = {s_q.gth, s_q.gtl};
   assign lt_limit = {s_q.lth, s_q.ltl};

   // [R1] compare each result
   adcwr_window #(
      .WIDTH              (16)
   ) u_window (
      .greater_than_limit (gt_limit),
      .less_than_limit    (lt_limit),
      .result_value       (result_value),
      .window_hit         (win_hit)
   );

   // ------------------------------
   // next-state logic
   // ------------------------------
   // next-state logic for the whole block
   always_comb
   begin
      logic       trig_event;
      logic       sw_busy_write;
      logic [2:0] trig_sel;
      logic       int_ref;
      logic       pin_rise;
      logic       gnd_sel;
      trig_event    = 1'b0;
      sw_busy_write = 1'b0;
      trig_sel      = s_q.ctrl0[adcwr_pkg::TRIG_LSB +: 3];
      int_ref       = 1'b0;
      pin_rise      = 1'b0;
      gnd_sel       = 1'b0;
      s_d           = s_q;

      // pin synchroniser; only the second stage feeds the edge detector
      s_d.pin_s1   = external_convert_start_pin;
      s_d.pin_s2   = s_q.pin_s1;
      s_d.pin_prev = s_q.pin_s2;
      pin_rise     = s_q.pin_s2 && !s_q.pin_prev;

      // byte writes from software
      if (sfr_wr)
      begin
         unique case (sfr_addr)
            adcwr_pkg::ADDR_CTRL0:
            begin
               s_d.ctrl0     = sfr_wdata;
               sw_busy_write = sfr_wdata[adcwr_pkg::BIT_BUSY];
            end
            adcwr_pkg::ADDR_GTL:  s_d.gtl  = sfr_wdata;
            adcwr_pkg::ADDR_GTH:  s_d.gth  = sfr_wdata;
            adcwr_pkg::ADDR_LTL:  s_d.ltl  = sfr_wdata;
            adcwr_pkg::ADDR_LTH:  s_d.lth  = sfr_wdata;
            adcwr_pkg::ADDR_REFC: s_d.refc = sfr_wdata;
            default: ;
         endcase
      end

      // [R17] bit-addressable control register
      if (sfr_bit_wr && sfr_bit_addr[7:3] == adcwr_pkg::ADDR_CTRL0[7:3])
      begin
         s_d.ctrl0[sfr_bit_addr[2:0]] = sfr_bit_wdata;
         if (sfr_bit_addr[2:0] == 3'(adcwr_pkg::BIT_BUSY))
            sw_busy_write = sfr_bit_wdata;
      end

      // [R20] start source selection
      unique case (trig_sel)
         adcwr_pkg::TRIG_SOFTWARE: trig_event = sw_busy_write;
         adcwr_pkg::TRIG_TIMER0:   trig_event = timer0_overflow;
         adcwr_pkg::TRIG_TIMER2:   trig_event = timer2_overflow;
         adcwr_pkg::TRIG_TIMER3:   trig_event = timer3_overflow;
         adcwr_pkg::TRIG_PIN:      trig_event = pin_rise;
         default:                  trig_event = 1'b0;  // reserved codes start nothing
      endcase

      // a trigger while busy is dropped; the core cannot take it
      // enables as written this cycle, so a disabling write wins
      s_d.start = trig_event && !s_q.ctrl0[adcwr_pkg::BIT_BUSY]
                  && (s_d.ctrl0[adcwr_pkg::BIT_ENABLE] || s_d.ctrl0[adcwr_pkg::BIT_BURST]);
      if (s_d.start)
         s_d.ctrl0[adcwr_pkg::BIT_BUSY] = 1'b1;
      else if (conversion_complete)
         s_d.ctrl0[adcwr_pkg::BIT_BUSY] = 1'b0;
      else if (!sw_busy_write || trig_sel != adcwr_pkg::TRIG_SOFTWARE)
         s_d.ctrl0[adcwr_pkg::BIT_BUSY] = s_q.ctrl0[adcwr_pkg::BIT_BUSY];

      // [R19] done flag set wins over clear
      if (conversion_complete)
         s_d.ctrl0[adcwr_pkg::BIT_DONE] = 1'b1;

      // [R18] window flag set wins
      if (result_valid && win_hit)
         s_d.ctrl0[adcwr_pkg::BIT_WIN] = 1'b1;

      // registered read data, one cycle after the strobe
      s_d.rdata = adcwr_pkg::RDATA_IDLE;
      if (sfr_rd)
      begin
         unique case (sfr_addr)
            // [R2] flag visible for polling
            adcwr_pkg::ADDR_CTRL0: s_d.rdata = s_q.ctrl0;
            adcwr_pkg::ADDR_GTL:   s_d.rdata = s_q.gtl;
            adcwr_pkg::ADDR_GTH:   s_d.rdata = s_q.gth;
            adcwr_pkg::ADDR_LTL:   s_d.rdata = s_q.ltl;
            adcwr_pkg::ADDR_LTH:   s_d.rdata = s_q.lth;
            adcwr_pkg::ADDR_REFC:  s_d.rdata = s_q.refc;
            default:               s_d.rdata = adcwr_pkg::RDATA_IDLE;
         endcase
      end

      // [R7] [R8] [R9] reference multiplexer code
      s_d.ref_sel = s_q.refc[adcwr_pkg::REF_SEL_LSB +: 2];
      // [R11] internal level bit
      s_d.ref_lvl = s_q.refc[adcwr_pkg::REF_LVL_BIT];
      int_ref     = s_q.ref_sel == adcwr_pkg::REF_INTERNAL;

      // [R10] reference on only while needed
      s_d.ref_power = int_ref && (converter_active || s_q.start);

      // [R12] [R13] analog ground in both phases
      gnd_sel = s_q.refc[adcwr_pkg::REF_GND_BIT];
      // [R14] sensor samples on chip ground
      s_d.gnd_track = gnd_sel && !temp_channel_selected;
      // [R15] low reference converts on chip ground
      s_d.gnd_convert = gnd_sel && !(int_ref && s_q.ref_lvl == adcwr_pkg::LVL_1V65);

      // [R16] sensor enable; analog side floats its output when low
      s_d.temp_en = s_q.refc[adcwr_pkg::REF_TEMP_SENSOR_ENABLE_BIT];
   end

   // ------------------------------
   // state register
   // ------------------------------
   // single register stage for all state
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_q          <= '0;
         s_q.ctrl0    <= adcwr_pkg::CTRL0_RESET;
         s_q.gtl      <= adcwr_pkg::LIMIT_RESET;
         s_q.gth      <= adcwr_pkg::LIMIT_RESET;
         s_q.ltl      <= adcwr_pkg::LIMIT_RESET;
         s_q.lth      <= adcwr_pkg::LIMIT_RESET;
         s_q.refc     <= adcwr_pkg::REFC_RESET;
         s_q.rdata    <= adcwr_pkg::RDATA_IDLE;
      end
      else
         s_q <= s_d;
   end

   // ------------------------------
   // outputs
   // ------------------------------
   // outputs straight from the state register
   assign sfr_rdata                = s_q.rdata;
   assign conv_start               = s_q.start;
   assign converter_enable         = s_q.ctrl0[adcwr_pkg::BIT_ENABLE];
   assign burst_enable             = s_q.ctrl0[adcwr_pkg::BIT_BURST];
   assign window_hit_flag          = s_q.ctrl0[adcwr_pkg::BIT_WIN];
   assign conversion_done_flag     = s_q.ctrl0[adcwr_pkg::BIT_DONE];
   assign reference_select         = s_q.ref_sel;
   assign internal_reference_level = s_q.ref_lvl;
   assign internal_ref_power       = s_q.ref_power;
   assign analog_ground_track      = s_q.gnd_track;
   assign analog_ground_convert    = s_q.gnd_convert;
   assign temp_sensor_enable       = s_q.temp_en;

endmodule

//--- adcwr_ctrl_assertions.sv
// port checker of the converter control block
`timescale 1ns/1ps
module adcwr_ctrl_chk
(
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst,
   // observed ports
   input wire logic       sfr_wr,
   input wire logic       sfr_bit_wr,
   input wire logic       result_valid,
   input wire logic       conversion_complete,
   input wire logic       converter_active,
   input wire logic       temp_channel_selected,
   input wire logic       conv_start,
   input wire logic       converter_enable,
   input wire logic       burst_enable,
   input wire logic       window_hit_flag,
   input wire logic       conversion_done_flag,
   input wire logic [1:0] reference_select,
   input wire logic       internal_reference_level,
   input wire logic       internal_ref_power,
   input wire logic       analog_ground_track,
   input wire logic       analog_ground_convert
);
   // ----------------------------------------------------------------
   // sequences and assertions
   // ----------------------------------------------------------------
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   sequence start_pulse;
      conv_start ##1 !conv_start;
   endsequence
   sequence core_idle;
      !converter_active && !conv_start;
   endsequence
   start_pulse_a: assert property (conv_start |-> start_pulse)
      else $error("start pulse too long");
   start_gate_a: assert property (conv_start |-> converter_enable || burst_enable)
      else $error("start while disabled");
   done_set_a: assert property (conversion_complete |=> conversion_done_flag)
      else $error("done flag not set");
   done_hold_a: assert property (conversion_done_flag && !sfr_wr && !sfr_bit_wr |=> conversion_done_flag)
      else $error("done flag lost");
   win_hold_a: assert property (window_hit_flag && !sfr_wr && !sfr_bit_wr |=> window_hit_flag)
      else $error("window flag lost");
   win_src_a: assert property (!window_hit_flag && !result_valid && !sfr_wr && !sfr_bit_wr |=> !window_hit_flag)
      else $error("window flag without result");
   ref_power_a: assert property (core_idle [*3] |-> !internal_ref_power)
      else $error("reference powered while idle");
   gnd_temp_a: assert property (temp_channel_selected [*2] |-> !analog_ground_track)
      else $error("sensor sampled on analog ground");
   gnd_ref_a: assert property ((reference_select == 2'h3 && !internal_reference_level) [*2] |-> !analog_ground_convert)
      else $error("low reference on analog ground");
endmodule

bind adcwr_ctrl adcwr_ctrl_chk u_chk (.mclk, .rst, .sfr_wr, .sfr_bit_wr, .result_valid,
   .conversion_complete, .converter_active, .temp_channel_selected, .conv_start,
   .converter_enable, .burst_enable, .window_hit_flag, .conversion_done_flag, .reference_select,
   .internal_reference_level, .internal_ref_power, .analog_ground_track, .analog_ground_convert);

//--- adcwr_core_model.sv
// behavioural converter core answering start pulses
`timescale 1ns/1ps
module adcwr_core_model
#(
   parameter int CONV_CYC = 4
)
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // start and value to convert
   input  wire logic        conv_start,
   input  wire logic [15:0] sample,
   // status to the control block
   output logic             converter_active,
   output logic             result_valid,
   output logic             conversion_complete,
   output logic      [15:0] result_value
);
   int cnt;
   // result bus toggles outside valid so stale data never matches
   always_ff @(posedge mclk)
   begin
      result_valid <= 1'b0;
      conversion_complete <= 1'b0;
      result_value <= ~result_value;
      if (rst)
      begin
         cnt <= 0;
         converter_active <= 1'b0;
         result_value <= 16'h0000;
      end
      else if (conv_start)
      begin
         cnt <= CONV_CYC;
         converter_active <= 1'b1;
      end
      else if (cnt == 1)
      begin
         cnt <= 0;
         converter_active <= 1'b0;
         result_valid <= 1'b1;
         conversion_complete <= 1'b1;
         result_value <= sample;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule

//--- testbench.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
   $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module testbench;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, sfr_rdata;
   logic        sfr_wr = 0, sfr_rd = 0, sfr_bit_wr = 0, sfr_bit_wdata = 0;
   logic        temp_channel_selected = 0, timer0_overflow = 0, timer2_overflow = 0;
   logic        timer3_overflow = 0, external_convert_start_pin = 0, pw_seen = 0;
   logic        result_valid, conversion_complete, converter_active, conv_start;
   logic        converter_enable, burst_enable, window_hit_flag, conversion_done_flag;
   logic        internal_reference_level, internal_ref_power, analog_ground_track;
   logic        analog_ground_convert, temp_sensor_enable;
   logic [1:0]  reference_select;
   logic [15:0] result_value, sample = 16'h0000;
   int          error_cnt = 0, n_tests = 0, cyc = 0;
   always #50 mclk = ~mclk;
   adcwr_ctrl dut (.mclk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
      .sfr_bit_addr, .sfr_bit_wr, .sfr_bit_wdata, .result_valid, .result_value,
      .conversion_complete, .converter_active, .temp_channel_selected, .timer0_overflow,
      .timer2_overflow, .timer3_overflow, .external_convert_start_pin, .conv_start,
      .converter_enable, .burst_enable, .window_hit_flag, .conversion_done_flag,
      .reference_select, .internal_reference_level, .internal_ref_power,
      .analog_ground_track, .analog_ground_convert, .temp_sensor_enable);
   adcwr_core_model #(.CONV_CYC(4)) core (.mclk, .rst, .conv_start, .sample,
      .converter_active, .result_valid, .conversion_complete, .result_value);
   // sticky view of reference power, and hang guard
   always @(posedge mclk)
   begin
      if (internal_ref_power === 1'b1) pw_seen <= 1'b1;
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         $display("mismatch timeout exp 0 got %0d", cyc);
         tally_and_finish;
      end
   end
   task tally_and_finish;
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge mclk);
      sfr_wr <= 1'b0;
   endtask
   task bw(input logic [7:0] a, input logic d);
      @(posedge mclk);
      sfr_bit_addr <= a;
      sfr_bit_wdata <= d;
      sfr_bit_wr <= 1'b1;
      @(posedge mclk);
      sfr_bit_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] ex);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1 `CHK("read data", ex, sfr_rdata)
   endtask
   task t_reset;
      logic [7:0] adr [7] = '{8'hE8, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hD1, 8'h55};
      foreach (adr[i]) rd(adr[i], 8'h00);
   endtask
   task t_ctrl;
      wr(adcwr_pkg::ADDR_CTRL0, 8'hC7);
      rd(adcwr_pkg::ADDR_CTRL0, 8'hC7);
      `CHK("enable out", 1'b1, converter_enable)
      `CHK("burst out", 1'b1, burst_enable)
      bw(8'hEF, 1'b0);
      rd(adcwr_pkg::ADDR_CTRL0, 8'h47);
      `CHK("enable out", 1'b0, converter_enable)
      wr(adcwr_pkg::ADDR_CTRL0, 8'h00);
   endtask
   task t_mid_reset;
      wr(adcwr_pkg::ADDR_REFC, 8'hFF);
      wr(adcwr_pkg::ADDR_CTRL0, 8'hC7);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      #1 `CHK("enable after reset", 1'b0, converter_enable)
      `CHK("sensor after reset", 1'b0, temp_sensor_enable)
      rd(adcwr_pkg::ADDR_CTRL0, 8'h00);
      rd(adcwr_pkg::ADDR_REFC, 8'h00);
   endtask
   task t_ref;
      logic [7:0] v;
      for (int i = 0; i < 16; i++)
      begin
         v = {i[2], 1'b0, i[3], i[1:0], i[0], 2'b00};
         wr(adcwr_pkg::ADDR_REFC, v);
         temp_channel_selected <= i[1];
         repeat (2) @(posedge mclk);
         #1 `CHK("ref select", i[1:0], reference_select)
         `CHK("ref level", i[2], internal_reference_level)
         `CHK("sensor on", i[0], temp_sensor_enable)
         `CHK("track gnd", i[3] & ~i[1], analog_ground_track)
         `CHK("conv gnd", i[3] & ~(i[1:0] == 2'h3 & ~i[2]), analog_ground_convert)
         rd(adcwr_pkg::ADDR_REFC, v);
      end
   endtask
   task win(input logic [15:0] gt, input logic [15:0] lt, input logic [15:0] res,
            input logic hit);
      wr(adcwr_pkg::ADDR_GTL, gt[7:0]);
      wr(adcwr_pkg::ADDR_GTH, gt[15:8]);
      wr(adcwr_pkg::ADDR_LTL, lt[7:0]);
      wr(adcwr_pkg::ADDR_LTH, lt[15:8]);
      wr(adcwr_pkg::ADDR_CTRL0, 8'h80);
      sample <= res;
      wr(adcwr_pkg::ADDR_CTRL0, 8'h90);
      for (int k = 0; k < 40 && conversion_done_flag !== 1'b1; k++) @(posedge mclk);
      #1 `CHK("window flag", hit, window_hit_flag)
      `CHK("done flag", 1'b1, conversion_done_flag)
      `CHK("ref power idle", 1'b0, internal_ref_power)
      rd(adcwr_pkg::ADDR_CTRL0, {4'hA, hit, 3'h0});
   endtask
   task t_trig(input logic [7:0] ctl, input logic [3:0] src, input int ex);
      int seen;
      seen = 0;
      wr(adcwr_pkg::ADDR_CTRL0, ctl);
      if (ctl[2:0] == 3'h0)
         bw(8'hEC, 1'b1);
      else
      begin
         @(posedge mclk);
         {external_convert_start_pin, timer3_overflow, timer2_overflow, timer0_overflow} <= src;
         @(posedge mclk);
         {external_convert_start_pin, timer3_overflow, timer2_overflow, timer0_overflow} <= 4'h0;
      end
      repeat (12)
      begin
         #1 if (conv_start === 1'b1) seen++;
         @(posedge mclk);
      end
      `CHK("starts", ex, seen)
      wr(adcwr_pkg::ADDR_CTRL0, 8'h00);
   endtask
   // main sequence
   initial
   begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_reset;
      t_ctrl;
      t_mid_reset;
      t_ref;
      wr(adcwr_pkg::ADDR_REFC, 8'h18);
      win(16'h0040, 16'h0080, 16'h0040, 1'b0);
      win(16'h0040, 16'h0080, 16'h0041, 1'b1);
      win(16'h0040, 16'h0080, 16'h007F, 1'b1);
      win(16'h0040, 16'h0080, 16'h0080, 1'b0);
      win(16'h0080, 16'h0040, 16'h003F, 1'b1);
      win(16'h0080, 16'h0040, 16'h0040, 1'b0);
      win(16'h0080, 16'h0040, 16'h0060, 1'b0);
      win(16'h0080, 16'h0040, 16'h0080, 1'b0);
      win(16'h0080, 16'h0040, 16'h0081, 1'b1);
      win(16'h0100, 16'hFFC0, 16'h8000, 1'b1);
      `CHK("ref power", 1'b1, pw_seen)
      t_trig(8'h80, 4'h0, 1);
      t_trig(8'h81, 4'h1, 1);
      t_trig(8'h82, 4'h2, 1);
      t_trig(8'h83, 4'h4, 1);
      t_trig(8'h84, 4'h8, 1);
      t_trig(8'h85, 4'hF, 0);
      t_trig(8'h81, 4'h2, 0);
      t_trig(8'h01, 4'h1, 0);
      t_trig(8'h41, 4'h1, 1);
      tally_and_finish;
   end
endmodule
